/* File: src/clock_status_pkg.sv */
// Package with register offsets, field positions, reset values and codes
`default_nettype none
package clock_status_pkg;
  localparam logic [7:0] global_control_status_addr        = 8'h00;
  localparam logic [7:0] output_pin_control_addr           = 8'h0e;
  localparam logic [7:0] clock_doubler_control_addr        = 8'h0f;
  localparam logic [7:0] cpu_identity_register_addr        = 8'h2e;
  localparam logic [7:0] revision_identity_register_addr   = 8'h2f;

  localparam int CAUSE_HI      = 7;
  localparam int CAUSE_LO      = 6;
  localparam int FORCE_BIT     = 5;
  localparam int CLKSEL_HI     = 4;
  localparam int CLKSEL_LO     = 2;
  localparam int PRIO_HI       = 1;
  localparam int PRIO_LO       = 0;
  localparam int PINSEL_HI     = 7;
  localparam int PINSEL_LO     = 6;
  localparam int DOUBLER_HI    = 2;
  localparam int DOUBLER_LO    = 0;

  localparam logic [1:0] CAUSE_NONE     = 2'h0;
  localparam logic [1:0] CAUSE_WATCHDOG = 2'h1;
  localparam logic [1:0] CAUSE_RESET    = 2'h3;

  localparam logic [2:0] CLKSEL_RESET   = 3'h0;
  localparam logic [1:0] PRIO_RESET     = 2'h0;
  localparam logic [1:0] PINSEL_RESET   = 2'h0;
  localparam logic [2:0] DOUBLER_RESET  = 3'h0;

  // Main path divider ratio, the doubled-and-divided net ratio and the clock pin divider
  localparam int MAIN_DIV       = 8;
  localparam int MAIN_DIV_DBL   = 4;
  localparam int PIN_DIV        = 2;

  // Doubler nominal low time: first step and step size in ns
  localparam int DBL_LOW_BASE_NS = 8;
  localparam int DBL_LOW_STEP_NS = 2;

  typedef enum logic [1:0] {
    PIN_PERIPH   = 2'b00,
    PIN_PERIPH_2 = 2'b01,
    PIN_LOW      = 2'b10,
    PIN_HIGH     = 2'b11
  } pin_mode_e;
endpackage : clock_status_pkg
`default_nettype wire

/* File: src/rate_divider.sv */
// Programmable enable-pulse divider, one pulse every ratio input cycles
`default_nettype none
module rate_divider #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             tick_i,
  input  wire logic [WIDTH-1:0] ratio_i,
  output logic                  pulse_o
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (tick_i) begin
      if (count + WIDTH'(1) >= ratio_i) begin
        count <= '0;
      end else begin
        count <= count + WIDTH'(1);
      end
    end
  end

  assign pulse_o = tick_i && (count + WIDTH'(1) >= ratio_i);
endmodule : rate_divider
`default_nettype wire

/* File: src/global_clock_status_control.sv */
// Global clock selection, reset cause reporting and periodic interrupt control
//
// What this block does
// - Status bits 7:6 read 01 after a watchdog timeout, 11 after reset, 00 otherwise, never 10.
// - A read of the control/status register clears the cause bits, unless a watchdog timeout arrives in the same cycle.
// - Writing one to bit 5 forces a periodic interrupt request.
// - Reading the register clears a pending periodic request and bit 5 always reads zero.
// - Clock select 000 divides both clocks by eight, 001 only the processor clock, 01x neither.
// - Clock select 1x0 and 1x1 run both clocks undivided from the 32 kHz source; 1x1 stops main.
// - The periodic field 00 disables periodic interrupts, 01..11 give priority 1..3.
// - Main path may be doubled and/or divided by eight; both together give main divided by four.
// - The peripheral clock may be halved before the clock pin, which also serves as a plain output.
// - The clock pin is made from internal clock enables, not the raw oscillator input.
// - The 32 kHz tick drives the watchdog, time/date counter and periodic generator.
// - With the main oscillator off, the 32 kHz tick clocks everything main normally clocks.
// - Two read-only identity registers hold processor type and revision, five specific bits each.
// - Doubler field zero disables doubling; nonzero picks low time 8 ns to 20 ns in 2 ns steps.
// - Pin control codes 00..11 give peripheral clock, its half, constant low, constant high.
`default_nettype none
module global_clock_status_control #(
  parameter logic [4:0] CPU_ID_CODE = 5'h0a, // Arbitrary value
  parameter logic [4:0] REV_ID_CODE = 5'h05  // Arbitrary value
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Internal I/O register port
  input  wire logic [7:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  // Oscillator ticks, one-cycle pulses of each source
  input  wire logic       main_tick_i,
  input  wire logic       main_doubled_tick_i,
  input  wire logic       slow_tick_i,
  input  wire logic       watchdog_timeout_i,
  input  wire logic       periodic_tick_i,
  // Clock enables and controls towards the rest of the chip
  output logic            cpu_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            slow_clk_en_o,
  output logic            main_osc_enable_o,
  output logic            doubler_enable_o,
  output logic      [4:0] doubler_low_ns_o,
  output logic            clk_pin_o,
  output logic            periodic_irq_o,
  output logic      [1:0] periodic_priority_o
);
  logic [1:0] cause;
  logic       periodic_pending;
  logic [2:0] clk_select;
  logic [1:0] periodic_prio;
  logic [1:0] pin_mode;
  logic [2:0] doubler_sel;
  logic       pin_phase;

  logic       status_rd;
  logic       status_wr;
  logic       slow_mode;
  logic       main_src_tick;
  logic [3:0] main_ratio;
  logic       main_div_pulse;
  logic       cpu_en;
  logic       periph_en;
  logic [4:0] low_time_table [8];
  logic       sel_status;
  logic       sel_pin;
  logic       sel_doubler;
  logic       sel_cpu_id;
  logic       sel_rev_id;
  logic       wr_force;
  logic [2:0] wr_clk_select;
  logic [1:0] wr_prio;
  logic [1:0] wr_pin_mode;
  logic [2:0] wr_doubler;

  // Address decode shared by reads and writes
  always_comb begin
    sel_status  = 1'b0;
    sel_pin     = 1'b0;
    sel_doubler = 1'b0;
    sel_cpu_id  = 1'b0;
    sel_rev_id  = 1'b0;
    if (io_addr_i == clock_status_pkg::global_control_status_addr) begin
      sel_status = 1'b1;
    end else if (io_addr_i == clock_status_pkg::output_pin_control_addr) begin
      sel_pin = 1'b1;
    end else if (io_addr_i == clock_status_pkg::clock_doubler_control_addr) begin
      sel_doubler = 1'b1;
    end else if (io_addr_i == clock_status_pkg::cpu_identity_register_addr) begin
      sel_cpu_id = 1'b1;
    end else if (io_addr_i == clock_status_pkg::revision_identity_register_addr) begin
      sel_rev_id = 1'b1;
    end
  end

  assign status_rd = io_rd_i && sel_status;
  assign status_wr = io_wr_i && sel_status;

  // Write data fields; the upper doubler bits are ignored
  assign wr_force      = io_wdata_i[clock_status_pkg::FORCE_BIT];
  assign wr_clk_select = io_wdata_i[clock_status_pkg::CLKSEL_HI:clock_status_pkg::CLKSEL_LO];
  assign wr_prio       = io_wdata_i[clock_status_pkg::PRIO_HI:clock_status_pkg::PRIO_LO];
  assign wr_pin_mode   = io_wdata_i[clock_status_pkg::PINSEL_HI:clock_status_pkg::PINSEL_LO];
  assign wr_doubler    = io_wdata_i[clock_status_pkg::DOUBLER_HI:clock_status_pkg::DOUBLER_LO];

  // Cause bits: reset leaves 11, watchdog sets 01, read clears; events win over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cause <= clock_status_pkg::CAUSE_RESET;
    end else begin
      if (watchdog_timeout_i) begin
        cause <= clock_status_pkg::CAUSE_WATCHDOG;
      end else if (status_rd) begin
        cause <= clock_status_pkg::CAUSE_NONE;
      end
    end
  end

  // Periodic request: set by tick or forced write, cleared by status read
  // A set in the same cycle as a read wins, so no request is lost
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      periodic_pending <= 1'b0;
    end else if ((periodic_tick_i && slow_tick_i && periodic_prio != 2'h0)
                 || (status_wr && wr_force)) begin
      periodic_pending <= 1'b1;
    end else if (status_rd) begin
      periodic_pending <= 1'b0;
    end
  end

  // Write-only control fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_select    <= clock_status_pkg::CLKSEL_RESET;
      periodic_prio <= clock_status_pkg::PRIO_RESET;
    end else if (status_wr) begin
      clk_select    <= wr_clk_select;
      periodic_prio <= wr_prio;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_mode <= clock_status_pkg::PINSEL_RESET;
    end else if (io_wr_i && sel_pin) begin
      pin_mode <= wr_pin_mode;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      doubler_sel <= clock_status_pkg::DOUBLER_RESET;
    end else if (io_wr_i && sel_doubler) begin
      doubler_sel <= wr_doubler;
    end
  end

  // Clock source selection
  assign slow_mode     = clk_select[2];
  assign main_src_tick = (doubler_sel != 3'h0) ? main_doubled_tick_i : main_tick_i;
  // Doubled ticks divided by eight give the net divide by four of main
  assign main_ratio    = (doubler_sel != 3'h0)
                       ? 4'(clock_status_pkg::MAIN_DIV)
                       : 4'(clock_status_pkg::MAIN_DIV);

  rate_divider #(
    .WIDTH (4)
  ) u_main_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (main_src_tick),
    .ratio_i (main_ratio),
    .pulse_o (main_div_pulse)
  );

  always_comb begin
    cpu_en    = 1'b0;
    periph_en = 1'b0;
    if (slow_mode) begin
      cpu_en    = slow_tick_i;
      periph_en = slow_tick_i;
    end else begin
      case (clk_select[1:0])
        2'b00: begin
          cpu_en    = main_div_pulse;
          periph_en = main_div_pulse;
        end
        2'b01: begin
          cpu_en    = main_div_pulse;
          periph_en = main_src_tick;
        end
        default: begin
          cpu_en    = main_src_tick;
          periph_en = main_src_tick;
        end
      endcase
    end
  end

  // Clock enables registered so the pin follows the internal clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_clk_en_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= cpu_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      periph_clk_en_o <= 1'b0;
    end else begin
      periph_clk_en_o <= periph_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slow_clk_en_o <= 1'b0;
    end else begin
      slow_clk_en_o <= slow_tick_i;
    end
  end

  // Main oscillator runs unless the slow source with stop is chosen
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_osc_enable_o <= 1'b1;
    end else begin
      main_osc_enable_o <= !(clk_select[2] && clk_select[0]);
    end
  end

  // Nominal doubled-clock low time per doubler code; code zero means off
  for (genvar g = 0; g < 8; g++) begin : g_low_time
    if (g == 0) begin : g_off
      assign low_time_table[g] = 5'h00;
    end else begin : g_on
      assign low_time_table[g] = 5'(clock_status_pkg::DBL_LOW_BASE_NS
                                    + clock_status_pkg::DBL_LOW_STEP_NS * (g - 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      doubler_enable_o <= 1'b0;
    end else begin
      doubler_enable_o <= (doubler_sel != 3'h0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      doubler_low_ns_o <= 5'h00;
    end else begin
      doubler_low_ns_o <= low_time_table[doubler_sel];
    end
  end

  // Half-rate phase of the peripheral clock for the pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_phase <= 1'b0;
    end else if (periph_en) begin
      pin_phase <= !pin_phase;
    end
  end

  // Clock pin: in mode 00 follows peripheral enables, so it tracks the internal clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_pin_o <= 1'b0;
    end else begin
      case (clock_status_pkg::pin_mode_e'(pin_mode))
        clock_status_pkg::PIN_PERIPH:   clk_pin_o <= periph_en;
        clock_status_pkg::PIN_PERIPH_2: clk_pin_o <= pin_phase;
        clock_status_pkg::PIN_LOW:      clk_pin_o <= 1'b0;
        default:                        clk_pin_o <= 1'b1;
      endcase
    end
  end

  // Interrupt request towards the priority logic
  assign periodic_irq_o      = periodic_pending && (periodic_prio != 2'h0);
  assign periodic_priority_o = periodic_prio;

  // Read data, registered
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      if (sel_status) begin
        io_rdata_o <= {cause, 6'h00};
      end else if (sel_cpu_id) begin
        io_rdata_o <= {3'h0, CPU_ID_CODE};
      end else if (sel_rev_id) begin
        io_rdata_o <= {3'h0, REV_ID_CODE};
      end else begin
        io_rdata_o <= 8'h00;
      end
    end
  end
endmodule : global_clock_status_control
`default_nettype wire

/* File: verif/clock_status_sva.sv */
// Port checks for the clock and status control block
`default_nettype none
module clock_status_sva (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] io_addr_i,
  input wire logic       io_rd_i,
  input wire logic       io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic       watchdog_timeout_i,
  input wire logic       periodic_tick_i,
  input wire logic       main_osc_enable_o,
  input wire logic       periodic_irq_o,
  input wire logic [1:0] periodic_priority_o
);
  logic rd0;
  logic wr0;
  assign rd0 = io_rd_i && io_addr_i == clock_status_pkg::global_control_status_addr;
  assign wr0 = io_wr_i && io_addr_i == clock_status_pkg::global_control_status_addr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_no_ten; rd0 |=> io_rdata_o[7:6] != 2'b10 && io_rdata_o[5:0] == 6'h00; endproperty
  a_no_ten: assert property (p_no_ten) else $error("bad status pattern");
  property p_rd_clear; rd0 && !watchdog_timeout_i ##1 rd0 && !watchdog_timeout_i
    |=> io_rdata_o[7:6] == 2'b00; endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("cause not cleared");
  property p_wd_cause; watchdog_timeout_i && !rd0 ##1 rd0 && !watchdog_timeout_i
    |=> io_rdata_o[7:6] == 2'b01; endproperty
  a_wd_cause: assert property (p_wd_cause) else $error("watchdog cause wrong");
  property p_force; wr0 && io_wdata_i[5] && io_wdata_i[1:0] != 2'b00 |=> periodic_irq_o; endproperty
  a_force: assert property (p_force) else $error("force gave no request");
  property p_prio; wr0 |=> periodic_priority_o == $past(io_wdata_i[1:0]); endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  property p_irq_prio; periodic_irq_o |-> periodic_priority_o != 2'b00; endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("request while disabled");
  property p_hold; periodic_irq_o && !rd0 && !wr0 |=> periodic_irq_o; endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_rd_irq; rd0 && !io_wr_i && !periodic_tick_i |=> !periodic_irq_o; endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("read kept request");
  property p_osc; wr0 ##1 !wr0
    |=> main_osc_enable_o == !($past(io_wdata_i[4], 2) && $past(io_wdata_i[2], 2)); endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
endmodule : clock_status_sva
`default_nettype wire

/* File: verif/test_global_clock_status_control.sv */
// Self-checking bench for the clock and status control block
`default_nettype none
module test_global_clock_status_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00, io_wdata_i = 8'h00, io_rdata_o;
  logic       main_tick_i = 1'b0, main_doubled_tick_i = 1'b0, slow_tick_i = 1'b0;
  logic       watchdog_timeout_i = 1'b0, periodic_tick_i = 1'b0;
  logic       cpu_clk_en_o, periph_clk_en_o, slow_clk_en_o, main_osc_enable_o;
  logic       doubler_enable_o, clk_pin_o, periodic_irq_o;
  logic [4:0] doubler_low_ns_o;
  logic [1:0] periodic_priority_o;
  int         fail_count = 0, checks_done = 0, m_cause = 3, r;
  int         pin_half = 0;
  always #2.5 clk_i = ~clk_i;
  global_clock_status_control dut (.clk_i, .rst_n_i, .io_addr_i, .io_rd_i, .io_wr_i,
    .io_wdata_i, .io_rdata_o, .main_tick_i, .main_doubled_tick_i, .slow_tick_i,
    .watchdog_timeout_i, .periodic_tick_i, .cpu_clk_en_o, .periph_clk_en_o, .slow_clk_en_o,
    .main_osc_enable_o, .doubler_enable_o, .doubler_low_ns_o, .clk_pin_o, .periodic_irq_o,
    .periodic_priority_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    checks_done++;
    if (tol == 0 ? got !== exp : ($isunknown(got) || got + tol < exp || got > exp + tol)) begin
      fail_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    @(posedge clk_i);
    chk(io_rdata_o & m, e);
  endtask : rd
  task automatic rds;
    logic [7:0] e;
    e = 8'(m_cause << 6);
    m_cause = 0;
    rd(8'h00, e, 8'hff);
  endtask : rds
  task automatic run_sel(input int sel, input int ec, input int ep, input logic dbl);
    int c = 0, p = 0, s = 0;
    int k = 0;
    logic q;
    wr(8'h00, 8'(sel << 2));
    q = clk_pin_o;
    for (int i = 0; i < 66; i++) begin
      main_tick_i <= i < 64 && i % 2 == 0;
      main_doubled_tick_i <= dbl && i < 64;
      slow_tick_i <= i < 64 && i % 8 == 1;
      @(posedge clk_i);
      c += cpu_clk_en_o;
      p += periph_clk_en_o;
      s += slow_clk_en_o;
      k += int'(clk_pin_o && !q);
      q = clk_pin_o;
    end
    chk(c, ec, 1);
    chk(p, ep, 1);
    chk(s, 8, 1);
    chk(main_osc_enable_o, sel != 5);
    chk(k, pin_half != 0 ? ep / 2 : ep, 1);
  endtask : run_sel
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    r = $urandom(45);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(main_osc_enable_o, 1);
    rds();
    io_rd_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    io_rd_i <= 1'b0;
    @(posedge clk_i);
    chk(io_rdata_o, 8'h00);
    watchdog_timeout_i <= 1'b1;
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b0;
    m_cause = 1;
    rds();
    rds();
    rd(8'h2e, 8'h0a, 8'h1f);
    wr(8'h2e, 8'($urandom));
    rd(8'h2e, 8'h0a, 8'h1f);
    rd(8'h2f, 8'h05, 8'h1f);
    rd(8'h33, 8'h00, 8'hff);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'h28 | 8'(p));
      repeat ($urandom_range(9, 1)) @(posedge clk_i);
      chk(periodic_irq_o, p != 0);
      chk(periodic_priority_o, p);
      rds();
      chk(periodic_irq_o, 0);
    end
    wr(8'h00, 8'h0a);
    slow_tick_i <= 1'b1;
    periodic_tick_i <= 1'b1;
    @(posedge clk_i);
    slow_tick_i <= 1'b0;
    periodic_tick_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(periodic_irq_o, 1);
    rds();
    for (int d = 0; d < 8; d++) begin
      wr(8'h0f, 8'(d) | 8'($urandom) & 8'hf8);
      @(posedge clk_i);
      chk(doubler_low_ns_o, d != 0 ? 6 + 2 * d : 0);
      chk(doubler_enable_o, d != 0);
    end
    run_sel(0, 8, 8, 1'b1);
    wr(8'h0f, 8'h00);
    run_sel(0, 4, 4, 1'b0);
    run_sel(1, 4, 32, 1'b0);
    run_sel(2, 32, 32, 1'b0);
    run_sel(3, 32, 32, 1'b0);
    run_sel(4, 8, 8, 1'b0);
    run_sel(5, 8, 8, 1'b0);
    wr(8'h0e, 8'h40);
    pin_half = 1;
    run_sel(2, 32, 32, 1'b0);
    pin_half = 0;
    wr(8'h0e, 8'h80);
    @(posedge clk_i);
    chk(clk_pin_o, 0);
    wr(8'h0e, 8'hc0);
    @(posedge clk_i);
    chk(clk_pin_o, 1);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(clk_pin_o, 0);
    chk(periodic_priority_o, 0);
    m_cause = 3;
    rds();
    tally_and_finish();
  end
endmodule : test_global_clock_status_control
bind global_clock_status_control clock_status_sva chk (.clk_i, .rst_n_i, .io_addr_i, .io_rd_i,
  .io_wr_i, .io_wdata_i, .io_rdata_o, .watchdog_timeout_i, .periodic_tick_i,
  .main_osc_enable_o, .periodic_irq_o, .periodic_priority_o);
`default_nettype wire
